// ==== ptm_timer.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - ten-bit up-counter on selected clock tick
// - comparators A and P on all ten bits
// - software clears counter only via enable rise
// - pause freezes counter, resumes from held value
// - three-bit field selects counter clock source
// - enable low holds count; rise clears, starts
// - enable rise forces compare pin to initial level
// - two-bit field selects operating mode
// - compare mode: none, low, high, toggle
// - pwm modes: inactive, active, pwm, pulse
// - match to initial level shows no change
// - output control sets initial or active level
// - polarity bit inverts pin in compare and pwm modes
// - clear select picks A or P/overflow
// - clear select ignored in pwm and pulse
// - counter readable as low and high byte
// - counter mode leaves pin undriven
// - two instances; second has no pin
// - clear on A raises only A flag
// - only comparator A changes compare pin
// - pwm period from P, duty from A
module ptm_timer
    import ptm_pkg::*;
#(
    parameter bit PIN_BONDED = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic subclock_tick,
    input wire logic external_clock_pin,
    output logic timer_output_pin,
    output logic timer_output_oe_n,
    output logic match_a_flag,
    output logic match_p_flag
);

    // ------------------------------------------------------------
    // external pin synchroniser
    // ------------------------------------------------------------
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic ext_s1_d, ext_s2_d, ext_s3_d;
    logic ext_rise, ext_fall;

    always_comb begin
        ext_s1_d = external_clock_pin;
        ext_s2_d = ext_s1_q;
        ext_s3_d = ext_s2_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_s1_d;
            ext_s2_q <= ext_s2_d;
            ext_s3_q <= ext_s3_d;
        end
    end

    // the second and third stages feed the edge detector
    assign ext_rise = ext_s2_q & ~ext_s3_q;
    assign ext_fall = ~ext_s2_q & ext_s3_q;

    // ------------------------------------------------------------
    // prescaler for the slower internal rates
    // ------------------------------------------------------------
    logic [5:0] div_q, div_d;

    always_comb begin
        div_d = div_q + 6'h01;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_d;
        end
    end

    // ------------------------------------------------------------
    // registers and counter state
    // ------------------------------------------------------------
    logic pause_q, pause_d;
    logic [2:0] cksel_q, cksel_d;
    logic on_q, on_d;
    logic [1:0] mode_q, mode_d;
    logic [1:0] pinfn_q, pinfn_d;
    logic oc_q, oc_d;
    logic pol_q, pol_d;
    logic rsv_q, rsv_d;
    logic cclr_q, cclr_d;
    logic [9:0] match_q, match_d;
    logic [9:0] per_q, per_d;
    logic [9:0] cnt_q, cnt_d;
    logic fa_q, fa_d;
    logic fp_q, fp_d;
    logic out_q, out_d;
    logic pin_q, pin_d;
    logic oe_n_q, oe_n_d;
    logic rdy_q, rdy_d;
    logic err_q, err_d;
    logic [31:0] rd_q, rd_d;

    logic src_tick, tick, cmpish, pulse_mode, pwm_mode;
    logic [9:0] nxt;
    logic a_hit, p_hit, clr, rise, ext_act, pwm_act, lvl;
    logic [10:0] per_eff;
    logic acc, first, wr, mapped;
    logic [7:0] rbyte;

    always_comb begin
        case (cksel_q)
            PTM_CK_SYS4: src_tick = (div_q[1:0] == PTM_DIV4_M[1:0]);
            PTM_CK_SYS: src_tick = 1'b1;
            PTM_CK_H16: src_tick = (div_q[3:0] == PTM_DIV16_M[3:0]);
            PTM_CK_H64: src_tick = (div_q == PTM_DIV64_M);
            PTM_CK_SUB0: src_tick = subclock_tick;
            PTM_CK_SUB1: src_tick = subclock_tick;
            PTM_CK_EXTR: src_tick = ext_rise;
            PTM_CK_EXTF: src_tick = ext_fall;
            default: src_tick = 1'b0;
        endcase
    end

    // counting stops when off or paused; the value is held
    assign tick = src_tick & on_q & ~pause_q;
    assign nxt = cnt_q + 10'h001;
    assign cmpish = (mode_q == PTM_MODE_CMP) | (mode_q == PTM_MODE_TC);
    assign pwm_mode = (mode_q == PTM_MODE_PWM) & (pinfn_q != PTM_FN_PULSE);
    assign pulse_mode = (mode_q == PTM_MODE_PWM) & (pinfn_q == PTM_FN_PULSE);

    // a zero value never matches, so the counter simply wraps past 3ff
    assign a_hit = tick & (match_q != 10'h000) & (nxt == match_q);
    // clear on A suppresses the P flag; period register unused for a pulse
    assign p_hit = tick & (per_q != 10'h000) & (nxt == per_q)
                   & ~(cmpish & cclr_q) & ~pulse_mode;
    assign clr = cmpish ? (cclr_q ? a_hit : p_hit) : p_hit;

    assign per_eff = {per_q == 10'h000, per_q};
    assign pwm_act = pwm_mode & ((cnt_q < match_q) | ({1'b0, match_q} >= per_eff));
    assign ext_act = (cksel_q == PTM_CK_EXTF) ? ext_fall : ext_rise;

    assign acc = psel & penable;
    assign first = acc & ~rdy_q;
    assign wr = acc & rdy_q & pwrite & pstrb[0];

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            PTM_OFF_CTL0: rbyte = {pause_q, cksel_q, on_q, 3'h0};
            PTM_OFF_CTL1: rbyte = {mode_q, pinfn_q, oc_q, pol_q, rsv_q, cclr_q};
            PTM_OFF_CNTL: rbyte = cnt_q[7:0];
            PTM_OFF_CNTH: rbyte = {6'h00, cnt_q[9:8]};
            PTM_OFF_MATL: rbyte = match_q[7:0];
            PTM_OFF_MATH: rbyte = {6'h00, match_q[9:8]};
            PTM_OFF_PERL: rbyte = per_q[7:0];
            PTM_OFF_PERH: rbyte = {6'h00, per_q[9:8]};
            PTM_OFF_FLAG: rbyte = {6'h00, fp_q, fa_q};
            default: begin
                rbyte = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        pause_d = pause_q;
        cksel_d = cksel_q;
        on_d = on_q;
        mode_d = mode_q;
        pinfn_d = pinfn_q;
        oc_d = oc_q;
        pol_d = pol_q;
        rsv_d = rsv_q;
        cclr_d = cclr_q;
        match_d = match_q;
        per_d = per_q;
        out_d = out_q;
        rdy_d = first;
        err_d = first & ~mapped;
        rd_d = first ? {24'h000000, rbyte} : rd_q;
        // hardware events on the enable bit
        if (pulse_mode && a_hit) begin
            on_d = 1'b0;
        end
        if (pulse_mode && ext_act && !on_q) begin
            on_d = 1'b1;
        end
        // software writes win over the hardware events above
        if (wr) begin
            case (paddr)
                PTM_OFF_CTL0: begin
                    pause_d = pwdata[PTM_C0_PAUSE];
                    cksel_d = pwdata[PTM_C0_CKSEL +: 3];
                    on_d = pwdata[PTM_C0_ON];
                end
                PTM_OFF_CTL1: begin
                    mode_d = pwdata[PTM_C1_MODE +: 2];
                    pinfn_d = pwdata[PTM_C1_PINFN +: 2];
                    oc_d = pwdata[PTM_C1_OC];
                    pol_d = pwdata[PTM_C1_POL];
                    rsv_d = pwdata[PTM_C1_RSV];
                    cclr_d = pwdata[PTM_C1_CCLR];
                end
                PTM_OFF_MATL: match_d[7:0] = pwdata[7:0];
                PTM_OFF_MATH: match_d[9:8] = pwdata[1:0];
                PTM_OFF_PERL: per_d[7:0] = pwdata[7:0];
                PTM_OFF_PERH: per_d[9:8] = pwdata[1:0];
                default: ;
            endcase
        end
        rise = on_d & ~on_q;
        // the counter has no write path; the enable rise or a clearing match clears it
        if (rise) begin
            cnt_d = PTM_RST_VAL;
        end else if (tick) begin
            cnt_d = clr ? PTM_RST_VAL : nxt;
        end else begin
            cnt_d = cnt_q;
        end
        // compare pin follows comparator A only
        if (rise) begin
            out_d = oc_d;
        end else if (a_hit && mode_q == PTM_MODE_CMP) begin
            case (pinfn_q)
                PTM_FN_LOW: out_d = 1'b0;
                PTM_FN_HIGH: out_d = 1'b1;
                PTM_FN_TOG: out_d = ~out_q;
                default: out_d = out_q;
            endcase
        end
        // flags: a new event wins over a write-one clear
        fa_d = fa_q;
        fp_d = fp_q;
        if (wr && paddr == PTM_OFF_FLAG) begin
            fa_d = fa_q & ~pwdata[PTM_FL_A];
            fp_d = fp_q & ~pwdata[PTM_FL_P];
        end
        fa_d = fa_d | a_hit;
        fp_d = fp_d | p_hit;
    end

    always_comb begin
        case (mode_q)
            PTM_MODE_CMP: lvl = out_q;
            PTM_MODE_PWM: begin
                case (pinfn_q)
                    PTM_FN_INACT: lvl = ~oc_q;
                    PTM_FN_ACT: lvl = oc_q;
                    PTM_FN_PWM: lvl = pwm_act ? oc_q : ~oc_q;
                    default: lvl = on_q ? oc_q : ~oc_q;
                endcase
            end
            default: lvl = 1'b0;
        endcase
        // an unbonded instance never drives its pin
        oe_n_d = ~(PIN_BONDED & ~mode_q[0]);
        pin_d = oe_n_d ? 1'b0 : (lvl ^ pol_q);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pause_q <= PTM_RST_CTL0[PTM_C0_PAUSE];
            cksel_q <= PTM_RST_CTL0[PTM_C0_CKSEL +: 3];
            on_q <= PTM_RST_CTL0[PTM_C0_ON];
            mode_q <= PTM_RST_CTL1[PTM_C1_MODE +: 2];
            pinfn_q <= PTM_RST_CTL1[PTM_C1_PINFN +: 2];
            oc_q <= PTM_RST_CTL1[PTM_C1_OC];
            pol_q <= PTM_RST_CTL1[PTM_C1_POL];
            rsv_q <= PTM_RST_CTL1[PTM_C1_RSV];
            cclr_q <= PTM_RST_CTL1[PTM_C1_CCLR];
            match_q <= PTM_RST_VAL;
            per_q <= PTM_RST_VAL;
            cnt_q <= PTM_RST_VAL;
            fa_q <= 1'b0;
            fp_q <= 1'b0;
            out_q <= 1'b0;
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= 32'h00000000;
        end else begin
            pause_q <= pause_d;
            cksel_q <= cksel_d;
            on_q <= on_d;
            mode_q <= mode_d;
            pinfn_q <= pinfn_d;
            oc_q <= oc_d;
            pol_q <= pol_d;
            rsv_q <= rsv_d;
            cclr_q <= cclr_d;
            match_q <= match_d;
            per_q <= per_d;
            cnt_q <= cnt_d;
            fa_q <= fa_d;
            fp_q <= fp_d;
            out_q <= out_d;
            pin_q <= pin_d;
            oe_n_q <= oe_n_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
            rd_q <= rd_d;
        end
    end

    assign prdata = rd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign timer_output_pin = pin_q;
    assign timer_output_oe_n = oe_n_q;
    assign match_a_flag = fa_q;
    assign match_p_flag = fp_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rise_clears: assert property (@(posedge clk) disable iff (!nrst)
        $rose(on_q) |-> cnt_q == 10'h000)
        else $error("counter not cleared on enable rise");

    a_off_holds: assert property (@(posedge clk) disable iff (!nrst)
        !on_q ##1 !on_q |-> $stable(cnt_q))
        else $error("counter moved while off");

    a_pause_holds: assert property (@(posedge clk) disable iff (!nrst)
        pause_q && on_q ##1 on_q |-> $stable(cnt_q))
        else $error("counter moved while paused");

    a_init_level: assert property (@(posedge clk) disable iff (!nrst)
        $rose(on_q) |-> out_q == oc_q)
        else $error("pin not at initial level");

    a_cmp_low: assert property (@(posedge clk) disable iff (!nrst)
        a_hit && mode_q == PTM_MODE_CMP && pinfn_q == PTM_FN_LOW && !rise |=> !out_q)
        else $error("compare low action missing");

    a_clear_on_a: assert property (@(posedge clk) disable iff (!nrst)
        a_hit && cmpish && cclr_q && !rise |=> cnt_q == 10'h000)
        else $error("counter not cleared on A match");

    a_no_p_flag: assert property (@(posedge clk) disable iff (!nrst)
        cmpish && cclr_q && !match_p_flag |=> !match_p_flag)
        else $error("P event while clearing on A");

    a_pin_polarity: assert property (@(posedge clk) disable iff (!nrst)
        !oe_n_d |=> timer_output_pin == ($past(lvl) ^ $past(pol_q)))
        else $error("pin polarity wrong");

    a_tc_pin_free: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == PTM_MODE_TC |=> timer_output_oe_n)
        else $error("pin driven in counter mode");

    a_cnt_high_read: assert property (@(posedge clk) disable iff (!nrst)
        first && paddr == PTM_OFF_CNTH |=> prdata == {30'h00000000, $past(cnt_q[9:8])})
        else $error("counter high byte readback wrong");

    a_pulse_stop: assert property (@(posedge clk) disable iff (!nrst)
        pulse_mode && a_hit && !wr |=> !on_q ##1 !on_q || pulse_mode)
        else $error("single pulse not ended by A match");

endmodule

// ==== ptm_pkg.sv ====
package ptm_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PTM_OFF_CTL0 = 8'h00;
    localparam logic [7:0] PTM_OFF_CTL1 = 8'h04;
    localparam logic [7:0] PTM_OFF_CNTL = 8'h08;
    localparam logic [7:0] PTM_OFF_CNTH = 8'h0c;
    localparam logic [7:0] PTM_OFF_MATL = 8'h10;
    localparam logic [7:0] PTM_OFF_MATH = 8'h14;
    localparam logic [7:0] PTM_OFF_PERL = 8'h18;
    localparam logic [7:0] PTM_OFF_PERH = 8'h1c;
    localparam logic [7:0] PTM_OFF_FLAG = 8'h20;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PTM_C0_PAUSE = 7;
    localparam int PTM_C0_CKSEL = 4;
    localparam int PTM_C0_ON = 3;
    localparam int PTM_C1_MODE = 6;
    localparam int PTM_C1_PINFN = 4;
    localparam int PTM_C1_OC = 3;
    localparam int PTM_C1_POL = 2;
    localparam int PTM_C1_RSV = 1;
    localparam int PTM_C1_CCLR = 0;
    localparam int PTM_FL_A = 0;
    localparam int PTM_FL_P = 1;

    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam int PTM_CW = 10;
    localparam logic [7:0] PTM_RST_CTL0 = 8'h00;
    localparam logic [7:0] PTM_RST_CTL1 = 8'h00;
    localparam logic [9:0] PTM_RST_VAL = 10'h000;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] PTM_MODE_CMP = 2'h0;
    localparam logic [1:0] PTM_MODE_UND = 2'h1;
    localparam logic [1:0] PTM_MODE_PWM = 2'h2;
    localparam logic [1:0] PTM_MODE_TC = 2'h3;
    localparam logic [1:0] PTM_FN_NONE = 2'h0;
    localparam logic [1:0] PTM_FN_LOW = 2'h1;
    localparam logic [1:0] PTM_FN_HIGH = 2'h2;
    localparam logic [1:0] PTM_FN_TOG = 2'h3;
    localparam logic [1:0] PTM_FN_INACT = 2'h0;
    localparam logic [1:0] PTM_FN_ACT = 2'h1;
    localparam logic [1:0] PTM_FN_PWM = 2'h2;
    localparam logic [1:0] PTM_FN_PULSE = 2'h3;
    localparam logic [2:0] PTM_CK_SYS4 = 3'h0;
    localparam logic [2:0] PTM_CK_SYS = 3'h1;
    localparam logic [2:0] PTM_CK_H16 = 3'h2;
    localparam logic [2:0] PTM_CK_H64 = 3'h3;
    localparam logic [2:0] PTM_CK_SUB0 = 3'h4;
    localparam logic [2:0] PTM_CK_SUB1 = 3'h5;
    localparam logic [2:0] PTM_CK_EXTR = 3'h6;
    localparam logic [2:0] PTM_CK_EXTF = 3'h7;
    localparam logic [5:0] PTM_DIV4_M = 6'h03;
    localparam logic [5:0] PTM_DIV16_M = 6'h0f;
    localparam logic [5:0] PTM_DIV64_M = 6'h3f;

endpackage

// ==== ptm_pin_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// far side: external clock source and output pin load
// ------------------------------------------------------------
module ptm_pin_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [7:0] half_cyc,
    output logic ext_clk,
    input wire logic pin,
    input wire logic pin_oe_n,
    output logic pin_seen
);
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] cnt_d;
    logic ext_q = 1'b0;
    logic ext_d;
    // the load pulls a released pin high, so a stale level never reads as driven
    assign pin_seen = pin_oe_n ? 1'b1 : pin;
    assign ext_clk = ext_q;
    // the source stands low between bursts instead of running free
    always_comb begin
        cnt_d = cnt_q + 8'h01;
        ext_d = ext_q;
        if (!run) begin
            cnt_d = 8'h00;
            ext_d = 1'b0;
        end else if (cnt_q == half_cyc - 8'h01) begin
            cnt_d = 8'h00;
            ext_d = ~ext_q;
        end
    end
    always_ff @(posedge clk) begin
        cnt_q <= cnt_d;
        ext_q <= ext_d;
    end
endmodule

// ==== ptm_timer_tb_top.sv ====
`timescale 1ns/100ps
module ptm_timer_tb_top;
    import ptm_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sub = 1'b0;
    logic run = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, pin, oe_n, fa, fp, ext, seen, oe2_n, err;
    logic [9:0] v, v2;
    int n_fail = 0;
    int check_count = 0;
    int hi, e;
    int dv[8] = '{4, 1, 16, 64, 8, 8, 8, 8};
    int pfn[6] = '{2, 2, 2, 2, 0, 1};
    int poc[6] = '{1, 1, 0, 1, 1, 1};
    int ppl[6] = '{0, 1, 0, 0, 0, 0};
    int pm[6] = '{3, 3, 3, 8, 3, 3};
    int ph[6] = '{24, 40, 40, 64, 0, 64};

    ptm_timer DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .subclock_tick(sub), .external_clock_pin(ext), .timer_output_pin(pin), .timer_output_oe_n(oe_n),
        .match_a_flag(fa), .match_p_flag(fp));
    ptm_timer #(.PIN_BONDED(1'b0)) DUT2 (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(), .pready(), .pslverr(),
        .subclock_tick(sub), .external_clock_pin(ext), .timer_output_pin(), .timer_output_oe_n(oe2_n),
        .match_a_flag(), .match_p_flag());
    ptm_pin_model PM (.clk(clk), .run(run), .half_cyc(8'h04), .ext_clk(ext), .pin(pin), .pin_oe_n(oe_n),
        .pin_seen(seen));

    // ------------------------------------------------------------
    // clock, subclock and bus tasks
    // ------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        forever begin
            repeat (7) @(posedge clk);
            sub <= 1'b1;
            @(posedge clk);
            sub <= 1'b0;
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) chk("pready", 1, 0);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic set10(input logic [7:0] a, input logic [9:0] x);
        apb(1'b1, a, {24'h0, x[7:0]});
        apb(1'b1, a + 8'h04, {30'h0, x[9:8]});
    endtask
    task automatic cnt(output logic [9:0] x);
        apb(1'b0, PTM_OFF_CNTL, 32'h0);
        x[7:0] = rdv[7:0];
        apb(1'b0, PTM_OFF_CNTH, 32'h0);
        x[9:8] = rdv[1:0];
        chk("count high byte", {30'h0, rdv[1:0]}, rdv);
    endtask
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, PTM_OFF_FLAG, 32'h0);
            n++;
        end while (rdv[b] !== 1'b1 && n < 100);
        chk("flag raised", 1, {31'h0, rdv[b]});
    endtask
    function automatic logic [31:0] cz(logic p, logic [2:0] k, logic on);
        return {24'h0, p, k, on, 3'h0};
    endfunction
    // reserved bit always written as zero
    function automatic logic [31:0] co(logic [1:0] m, logic [1:0] f, logic oc, logic pol, logic cc);
        return {24'h0, m, f, oc, pol, 1'b0, cc};
    endfunction

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 0, rdv);
        end
        apb(1'b1, PTM_OFF_CNTL, 32'hff);
        apb(1'b0, PTM_OFF_CNTL, 32'h0);
        chk("counter write", 0, rdv);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped error", 1, {31'h0, err});
        $display("test reset done");
        apb(1'b1, PTM_OFF_CTL1, co(PTM_MODE_TC, 2'h0, 1'b0, 1'b0, 1'b0));
        repeat (2) @(posedge clk);
        chk("pin released", 1, {31'h0, oe_n});
        for (int k = 0; k < 8; k++) begin
            run <= (k >= 6);
            apb(1'b1, PTM_OFF_CTL0, cz(1'b1, 3'(k), 1'b0));
            apb(1'b1, PTM_OFF_CTL0, cz(1'b1, 3'(k), 1'b1));
            cnt(v);
            chk("count cleared", 0, {22'h0, v});
            apb(1'b1, PTM_OFF_CTL0, cz(1'b0, 3'(k), 1'b1));
            repeat (256) @(posedge clk);
            apb(1'b1, PTM_OFF_CTL0, cz(1'b1, 3'(k), 1'b1));
            cnt(v);
            e = 260 / dv[k];
            chk("count rate", 1, {31'h0, int'(v) + 2 >= e && int'(v) <= e + 2});
            repeat (20) @(posedge clk);
            cnt(v2);
            chk("paused count", {22'h0, v}, {22'h0, v2});
        end
        run <= 1'b0;
        apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SYS, 1'b0));
        cnt(v);
        repeat (50) @(posedge clk);
        cnt(v2);
        chk("held when off", {22'h0, v}, {22'h0, v2});
        $display("test clock select done");
        set10(PTM_OFF_MATL, 10'd4);
        set10(PTM_OFF_PERL, 10'd3);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SUB0, 1'b0));
            apb(1'b1, PTM_OFF_FLAG, 32'h3);
            apb(1'b1, PTM_OFF_CTL1, co(PTM_MODE_CMP, 2'(f), 1'b0, 1'b0, 1'b1));
            apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SUB0, 1'b1));
            repeat (2) @(posedge clk);
            chk("pin at enable", 0, {31'h0, seen});
            chk("unbonded pin", 1, {31'h0, oe2_n});
            wait_flag(PTM_FL_A);
            chk("pin after match", {31'h0, f[1]}, {31'h0, seen});
            chk("a flag output", 1, {31'h0, fa});
            chk("p flag output", 0, {31'h0, fp});
            apb(1'b0, PTM_OFF_FLAG, 32'h0);
            chk("flags clear on a", 1, rdv);
            cnt(v);
            chk("count below match", 1, {31'h0, v < 10'd4});
        end
        apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SUB0, 1'b0));
        apb(1'b1, PTM_OFF_FLAG, 32'h3);
        set10(PTM_OFF_PERL, 10'd6);
        apb(1'b1, PTM_OFF_CTL1, co(PTM_MODE_CMP, PTM_FN_NONE, 1'b0, 1'b0, 1'b0));
        apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SUB0, 1'b1));
        wait_flag(PTM_FL_P);
        chk("p flag output", 1, {31'h0, fp});
        apb(1'b0, PTM_OFF_FLAG, 32'h0);
        chk("flags clear on p", 3, rdv);
        $display("test compare done");
        set10(PTM_OFF_PERL, 10'd8);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SYS, 1'b0));
            set10(PTM_OFF_MATL, 10'(pm[i]));
            apb(1'b1, PTM_OFF_CTL1, co(PTM_MODE_PWM, 2'(pfn[i]), 1'(poc[i]), 1'(ppl[i]), 1'b1));
            apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SYS, 1'b1));
            repeat (16) @(posedge clk);
            hi = 0;
            repeat (64) begin
                @(posedge clk);
                if (seen === 1'b1) hi++;
            end
            chk("pwm high count", ph[i], hi);
        end
        $display("test pwm done");
        apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SYS, 1'b0));
        set10(PTM_OFF_MATL, 10'd20);
        apb(1'b1, PTM_OFF_CTL1, co(PTM_MODE_PWM, PTM_FN_PULSE, 1'b1, 1'b0, 1'b0));
        apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_SYS, 1'b1));
        repeat (2) @(posedge clk);
        chk("pulse leading", 1, {31'h0, seen});
        repeat (40) @(posedge clk);
        chk("pulse trailing", 0, {31'h0, seen});
        apb(1'b0, PTM_OFF_CTL0, 32'h0);
        chk("enable after pulse", 32'h10, rdv);
        // a rising edge on the external pin starts the pulse while the timer is off
        apb(1'b1, PTM_OFF_CTL0, cz(1'b0, PTM_CK_EXTR, 1'b0));
        run <= 1'b1;
        repeat (16) @(posedge clk);
        chk("pulse by pin", 1, {31'h0, seen});
        run <= 1'b0;
        apb(1'b0, PTM_OFF_CTL0, 32'h0);
        chk("enable by pin", 32'h68, rdv);
        $display("test single pulse done");
        finish_test;
    end
endmodule
